// file: hw/timer_output_compare.sv
// Timer output compare top: registers, counter, interrupt.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "tmr_oc_cfg.svh"
module timer_output_compare (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    output logic COMPARE_PIN_A_O,
    output logic COMPARE_PIN_B_O,
    output logic TIMER_IRQ_O
);
    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    tmr_oc_pkg::bus_req_s req;
    assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
    logic [7:0] per_en_ff, mode_ff, ctrl_ff, pin_io_ff, irq_mask_ff;
    logic [7:0] stat_ff, evt_mask_ff, rdata_ff;
    logic [15:0] gra_ff, grb_ff, cnt_ff;
    logic [7:0] gra_lo_ff, grb_lo_ff;
    wire gate_on = per_en_ff[`BIT_CLOCK_GATE];
    // Gate off holds every timer register but per_en_ff and irq_mask_ff in reset and drops writes to them.
    wire hold = RST_I | ~gate_on;
    wire tmr_wr = req.wr & gate_on;
    wire run = mode_ff[`BIT_COUNT_RUN];
    wire pwm = mode_ff[`BIT_PWM];
    wire wr_per = req.wr & (req.addr == `OFS_PER_EN);
    wire wr_mode = tmr_wr & (req.addr == `OFS_MODE);
    wire wr_ctrl = tmr_wr & (req.addr == `OFS_CTRL);
    // Pin control is only taken while the counter is stopped.
    wire wr_pio = tmr_wr & (req.addr == `OFS_PIN_IO) & ~run;
    wire wr_gral = tmr_wr & (req.addr == `OFS_GRA_LO);
    wire wr_grah = tmr_wr & (req.addr == `OFS_GRA_HI);
    wire wr_grbl = tmr_wr & (req.addr == `OFS_GRB_LO);
    wire wr_grbh = tmr_wr & (req.addr == `OFS_GRB_HI);
    wire wr_cntl = tmr_wr & (req.addr == `OFS_CNT_LO);
    wire wr_cnth = tmr_wr & (req.addr == `OFS_CNT_HI);
    wire wr_imsk = req.wr & (req.addr == `OFS_IRQ_MASK);
    wire wr_stat = tmr_wr & (req.addr == `OFS_IRQ_STAT);
    wire wr_emsk = tmr_wr & (req.addr == `OFS_EVT_MASK);
    // ----------------------------------------------------------------
    // Compare channels
    // ----------------------------------------------------------------
    logic match_a, match_b;
    compare_channel u_chan_a (
        .clk_i(REF_CLK_I),
        .hold_i(hold),
        .count_i(cnt_ff),
        .compare_i(gra_ff),
        .capture_fn_i(pin_io_ff[`BIT_PIN_A_FN]),
        .pwm_i(pwm),
        .code_i(pin_io_ff[`BIT_PIN_A_LO +: 2]),
        .match_o(match_a),
        .pin_o(COMPARE_PIN_A_O)
    );
    compare_channel u_chan_b (
        .clk_i(REF_CLK_I),
        .hold_i(hold),
        .count_i(cnt_ff),
        .compare_i(grb_ff),
        .capture_fn_i(pin_io_ff[`BIT_PIN_B_FN]),
        .pwm_i(pwm),
        .code_i(pin_io_ff[`BIT_PIN_B_LO +: 2]),
        .match_o(match_b),
        .pin_o(COMPARE_PIN_B_O)
    );
    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    wire tmr_oc_pkg::clr_src_e clr_src = tmr_oc_pkg::clr_src_e'(ctrl_ff[`BIT_CLR_LO +: 2]);
    wire clr_hit = (clr_src == tmr_oc_pkg::CLR_ON_A & match_a) |
                   (clr_src == tmr_oc_pkg::CLR_ON_B & match_b);
    logic [15:0] nxt_cnt;
    always_comb begin
        nxt_cnt = cnt_ff;
        if (wr_cntl) begin
            nxt_cnt = {cnt_ff[15:8], req.wdata};
        end else if (wr_cnth) begin
            nxt_cnt = {req.wdata, cnt_ff[7:0]};
        end else if (run) begin
            // A clear lands on zero in place of the increment.
            if (clr_hit) begin
                nxt_cnt = 16'h0000;
            end else begin
                nxt_cnt = cnt_ff + 16'h0001;
            end
        end
    end
    // ----------------------------------------------------------------
    // Interrupt status: bit 0 match A, bit 1 match B
    // ----------------------------------------------------------------
    wire [7:0] evt = {6'h00, match_b & run, match_a & run};
    // Set wins over a write-one clear in the same cycle.
    wire [7:0] nxt_stat = (stat_ff & ~(wr_stat ? req.wdata : 8'h00)) | evt;
    assign TIMER_IRQ_O = |(stat_ff & evt_mask_ff) & ~irq_mask_ff[`BIT_IRQ_MASK];
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            per_en_ff <= `RST_REG8;
            irq_mask_ff <= `RST_IRQ_MASK;
        end else begin
            if (wr_per) begin
                per_en_ff <= req.wdata;
            end
            if (wr_imsk) begin
                irq_mask_ff <= req.wdata;
            end
        end
    end
    always_ff @(posedge REF_CLK_I) begin
        if (hold) begin
            mode_ff <= `RST_REG8;
            ctrl_ff <= `RST_REG8;
            pin_io_ff <= `RST_REG8;
            stat_ff <= `RST_REG8;
            evt_mask_ff <= `RST_EVT_MASK;
            gra_ff <= 16'hFFFF;
            grb_ff <= 16'hFFFF;
            gra_lo_ff <= `RST_REG8;
            grb_lo_ff <= `RST_REG8;
            cnt_ff <= `RST_REG16;
        end else begin
            if (wr_mode) mode_ff <= req.wdata;
            if (wr_ctrl) ctrl_ff <= req.wdata;
            if (wr_pio) pin_io_ff <= req.wdata;
            if (wr_emsk) evt_mask_ff <= req.wdata;
            if (wr_gral) gra_lo_ff <= req.wdata;
            if (wr_grbl) grb_lo_ff <= req.wdata;
            // The low byte is staged so a 16-bit compare value changes at once.
            if (wr_grah) gra_ff <= {req.wdata, gra_lo_ff};
            if (wr_grbh) grb_ff <= {req.wdata, grb_lo_ff};
            stat_ff <= nxt_stat;
            cnt_ff <= nxt_cnt;
        end
    end
    // ----------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        case (req.addr)
            `OFS_PER_EN: rd_mux = per_en_ff;
            `OFS_MODE: rd_mux = mode_ff;
            `OFS_CTRL: rd_mux = ctrl_ff;
            `OFS_PIN_IO: rd_mux = pin_io_ff;
            `OFS_GRA_LO: rd_mux = gra_ff[7:0];
            `OFS_GRA_HI: rd_mux = gra_ff[15:8];
            `OFS_GRB_LO: rd_mux = grb_ff[7:0];
            `OFS_GRB_HI: rd_mux = grb_ff[15:8];
            `OFS_CNT_LO: rd_mux = cnt_ff[7:0];
            `OFS_CNT_HI: rd_mux = cnt_ff[15:8];
            `OFS_IRQ_MASK: rd_mux = irq_mask_ff;
            `OFS_IRQ_STAT: rd_mux = stat_ff;
            `OFS_EVT_MASK: rd_mux = evt_mask_ff;
            default: rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= req.rd ? rd_mux : 8'h00;
        end
    end
    assign RDATA_O = rdata_ff;
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_HOLD: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        !gate_on |=> (cnt_ff == 16'h0000) && (mode_ff == 8'h00))
        else $error("Timer not held while gate off");
    AST_STOP: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (!run && !wr_cntl && !wr_cnth && gate_on && !wr_per) |=> $stable(cnt_ff))
        else $error("Counter moved while stopped");
    AST_INC: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (run && gate_on && !clr_hit && !wr_cntl && !wr_cnth && !wr_per)
        |=> cnt_ff == $past(cnt_ff) + 16'h0001)
        else $error("Counter did not increment");
    AST_CLR: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (run && clr_hit && gate_on && !wr_cntl && !wr_cnth && !wr_per)
        |=> cnt_ff == 16'h0000)
        else $error("Counter not cleared on match");
    AST_TOG: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (match_b && gate_on && !wr_per && pin_io_ff[5:4] == 2'h3)
        |=> COMPARE_PIN_B_O != $past(COMPARE_PIN_B_O))
        else $error("Pin B did not toggle");
    AST_LEVEL: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (match_a && gate_on && !wr_per && pin_io_ff[1:0] == 2'h2)
        |=> COMPARE_PIN_A_O)
        else $error("Pin A not high after match");
    AST_MATCH: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (gate_on && !pwm && !pin_io_ff[6] && cnt_ff == grb_ff) |-> match_b)
        else $error("Match B missed");
    AST_MASK: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        irq_mask_ff[3] |-> !TIMER_IRQ_O)
        else $error("Interrupt passed while masked");
    AST_PIO: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (run && gate_on && !wr_per) |=> $stable(pin_io_ff))
        else $error("Pin control changed while running");
    AST_IDLE: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (gate_on && !u_chan_a.seen_ff && !match_a && pin_io_ff[1:0] == 2'h1 && !wr_per)
        |=> COMPARE_PIN_A_O)
        else $error("Idle level wrong");
endmodule

// file: hw/tmr_oc_cfg.svh
// Constants for the timer output compare block: offsets, fields, resets.
`ifndef TMR_OC_CFG_SVH
`define TMR_OC_CFG_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_PER_EN 4'h0
`define OFS_MODE 4'h1
`define OFS_CTRL 4'h2
`define OFS_PIN_IO 4'h3
`define OFS_GRA_LO 4'h4
`define OFS_GRA_HI 4'h5
`define OFS_GRB_LO 4'h6
`define OFS_GRB_HI 4'h7
`define OFS_CNT_LO 4'h8
`define OFS_CNT_HI 4'h9
`define OFS_IRQ_MASK 4'hA
`define OFS_IRQ_STAT 4'hB
`define OFS_EVT_MASK 4'hC
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_CLOCK_GATE 6
`define BIT_COUNT_RUN 7
`define BIT_PWM 0
`define BIT_IRQ_MASK 3
`define BIT_CLR_LO 5
`define BIT_PIN_A_LO 0
`define BIT_PIN_A_FN 2
`define BIT_PIN_B_LO 4
`define BIT_PIN_B_FN 6
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_IRQ_MASK 8'hFF
`define RST_REG8 8'h00
`define RST_REG16 16'h0000
`define RST_EVT_MASK 8'h03
`endif

// file: hw/tmr_oc_pkg.sv
// Types for the timer output compare block.
package tmr_oc_pkg;
    typedef enum logic [1:0] {
        CLR_NONE = 2'h0,
        CLR_ON_A = 2'h1,
        CLR_ON_B = 2'h2,
        CLR_BAD = 2'h3
    } clr_src_e;
    typedef enum logic [1:0] {
        PIN_OFF = 2'h0,
        PIN_LOW = 2'h1,
        PIN_HIGH = 2'h2,
        PIN_TOGGLE = 2'h3
    } pin_code_e;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;
endpackage

// file: hw/compare_channel.sv
// One output compare channel: match detection and pin level.
`timescale 1ns/1ps
`include "tmr_oc_cfg.svh"
module compare_channel (
    input wire logic clk_i,
    input wire logic hold_i,
    input wire logic [15:0] count_i,
    input wire logic [15:0] compare_i,
    input wire logic capture_fn_i,
    input wire logic pwm_i,
    input wire logic [1:0] code_i,
    output logic match_o,
    output logic pin_o
);
    logic pin_ff;
    logic nxt_pin;
    logic seen_ff;
    wire compare_mode = ~capture_fn_i & ~pwm_i;
    assign match_o = compare_mode & (count_i == compare_i);
    wire tmr_oc_pkg::pin_code_e code = tmr_oc_pkg::pin_code_e'(code_i);
    // Before the first match the idle level follows the code.
    wire idle_lvl = (code == tmr_oc_pkg::PIN_LOW);
    always_comb begin
        nxt_pin = pin_ff;
        if (match_o) begin
            case (code)
                tmr_oc_pkg::PIN_LOW: nxt_pin = 1'b0;
                tmr_oc_pkg::PIN_HIGH: nxt_pin = 1'b1;
                tmr_oc_pkg::PIN_TOGGLE: nxt_pin = ~pin_ff;
                default: nxt_pin = pin_ff;
            endcase
        end else if (!seen_ff) begin
            nxt_pin = idle_lvl;
        end
    end
    always_ff @(posedge clk_i) begin
        if (hold_i) begin
            pin_ff <= 1'b0;
            seen_ff <= 1'b0;
        end else begin
            pin_ff <= nxt_pin;
            seen_ff <= seen_ff | (match_o & (code != tmr_oc_pkg::PIN_OFF));
        end
    end
    assign pin_o = pin_ff;
endmodule

// file: testbench/pin_load.sv
// Load model on the two compare output pins, timing the gap between pin changes.
`timescale 1ns/1ps
module pin_load (
    input wire logic clk_i,
    input wire logic pin_a_i,
    input wire logic pin_b_i,
    output logic [16:0] gap_a_o,
    output logic [16:0] gap_b_o
);
    logic [16:0] cnt_a_ff = 17'h0;
    logic [16:0] cnt_b_ff = 17'h0;
    logic last_a_ff = 1'b0;
    logic last_b_ff = 1'b0;
    // The load only listens, so a gap is the full cycle count between two changes.
    always @(posedge clk_i) begin
        last_a_ff <= pin_a_i;
        last_b_ff <= pin_b_i;
        cnt_a_ff <= (pin_a_i !== last_a_ff) ? 17'h1 : cnt_a_ff + 17'h1;
        cnt_b_ff <= (pin_b_i !== last_b_ff) ? 17'h1 : cnt_b_ff + 17'h1;
        if (pin_a_i !== last_a_ff) gap_a_o <= cnt_a_ff;
        if (pin_b_i !== last_b_ff) gap_b_o <= cnt_b_ff;
    end
endmodule

// file: testbench/timer_output_compare_tb.sv
// Self-checking bench for the timer output compare block.
`timescale 1ns/1ps
`include "tmr_oc_cfg.svh"
module timer_output_compare_tb;
    logic clk;
    logic rst;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic pin_a;
    logic pin_b;
    logic irq;
    logic [16:0] gap_a;
    logic [16:0] gap_b;
    logic seen;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed;
    int m;
    int n;
    int model_reg [16];

    timer_output_compare u_dut (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .COMPARE_PIN_A_O(pin_a),
        .COMPARE_PIN_B_O(pin_b), .TIMER_IRQ_O(irq));
    pin_load u_load (.clk_i(clk), .pin_a_i(pin_a), .pin_b_i(pin_b), .gap_a_o(gap_a),
        .gap_b_o(gap_b));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // The model drops gated writes and pin control writes made while running.
    task automatic wrb(input logic [3:0] a, input logic [7:0] d);
        logic ok;
        ok = (a == 4'h0) || (a == 4'hA) || (model_reg[0][6] && !(a == 4'h3 && model_reg[1][7]));
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (ok) model_reg[a] = d;
        if (a == 4'h0 && !d[6]) for (int i = 1; i < 4; i++) model_reg[i] = 0;
        @(posedge clk);
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", {9'h0, exp}, {9'h0, rdata});
        @(posedge clk);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 44;
        rst = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        for (int i = 0; i < 16; i++) model_reg[i] = 0;
        model_reg[10] = 8'hFF;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(`OFS_IRQ_MASK, 8'hFF);
        rdc(`OFS_EVT_MASK, 8'h03);
        wrb(`OFS_MODE, 8'h80);
        rdc(`OFS_MODE, model_reg[1][7:0]);
        rdc(4'hD, 8'h00);
        wrb(`OFS_PER_EN, 8'h40);
        rdc(`OFS_PER_EN, 8'h40);
        wrb(`OFS_PIN_IO, 8'h21);
        wrb(`OFS_GRA_LO, 8'h03);
        wrb(`OFS_GRA_HI, 8'h00);
        wrb(`OFS_GRB_LO, 8'h03);
        wrb(`OFS_GRB_HI, 8'h00);
        #1;
        chk("idle_a", 17'h1, {16'h0, pin_a});
        chk("idle_b", 17'h0, {16'h0, pin_b});
        wrb(`OFS_MODE, 8'h80);
        repeat (10) @(posedge clk);
        #1;
        chk("low_a", 17'h0, {16'h0, pin_a});
        chk("high_b", 17'h1, {16'h0, pin_b});
        chk("irq_masked", 17'h0, {16'h0, irq});
        wrb(`OFS_IRQ_MASK, 8'hF7);
        #1;
        chk("irq_open", 17'h1, {16'h0, irq});
        rdc(`OFS_IRQ_STAT, 8'h03);
        wrb(`OFS_MODE, 8'h00);
        wrb(`OFS_IRQ_STAT, 8'h03);
        #1;
        chk("irq_clear", 17'h0, {16'h0, irq});
        wrb(`OFS_CNT_HI, 8'h00);
        wrb(`OFS_CNT_LO, 8'h20);
        rdc(`OFS_CNT_LO, 8'h20);
        repeat (5) @(posedge clk);
        rdc(`OFS_CNT_LO, 8'h20);
        for (int k = 1; k < 3; k++) begin
            m = 2 + ($random(seed) & 15);
            n = m + 1 + ($random(seed) & 15);
            wrb(`OFS_MODE, 8'h00);
            wrb(`OFS_PIN_IO, 8'h33);
            wrb(`OFS_CTRL, 8'(k << 5));
            wrb(`OFS_GRA_LO, 8'(m));
            wrb(`OFS_GRA_HI, 8'h00);
            wrb(`OFS_GRB_LO, 8'(n));
            wrb(`OFS_GRB_HI, 8'h00);
            wrb(`OFS_CNT_LO, 8'h00);
            wrb(`OFS_MODE, 8'h80);
            wrb(`OFS_PIN_IO, 8'h11);
            rdc(`OFS_PIN_IO, model_reg[3][7:0]);
            repeat (4 * n + 12) @(posedge clk);
            chk("gap_a", (k == 1) ? 17'(m + 1) : 17'(n + 1), gap_a);
            if (k == 2) chk("gap_b", 17'(n + 1), gap_b);
        end
        wrb(`OFS_MODE, 8'h00);
        wrb(`OFS_CTRL, 8'h00);
        wrb(`OFS_CNT_HI, 8'hFF);
        wrb(`OFS_CNT_LO, 8'hFE);
        wrb(`OFS_GRA_LO, 8'h00);
        wrb(`OFS_GRA_HI, 8'h00);
        wrb(`OFS_MODE, 8'h80);
        #1;
        seen = pin_a;
        repeat (4) @(posedge clk);
        #1;
        chk("wrap_a", {16'h0, ~seen}, {16'h0, pin_a});
        wrb(`OFS_PER_EN, 8'h00);
        wrb(`OFS_PIN_IO, 8'h22);
        #1;
        chk("gated_a", 17'h0, {16'h0, pin_a});
        wrb(`OFS_PER_EN, 8'h40);
        rdc(`OFS_PIN_IO, model_reg[3][7:0]);
        rdc(`OFS_MODE, model_reg[1][7:0]);
        print_verdict();
    end
endmodule
